//--- design/fault_action_engine.sv
// Carries out one fault-response byte: delay, shutdown, retry, hold-off.
// Assumes fault is a clean level on the same clock.
module fault_action_engine #(
  parameter int CNT_W = 16
) (
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic             ce,
  input  wire logic             fault,
  input  wire logic             run_req,
  input  wire logic             halt,
  input  wire logic [7:0]       action,
  input  wire logic [CNT_W-1:0] unit_cycles,
  output logic                  allow_q,
  output logic                  latched_q
);

  initial begin
    if (CNT_W < 4 || CNT_W > 30) begin
      $error("fault_action_engine: unsupported counter width");
    end
  end

  typedef enum logic [2:0] {
    PH_IDLE, PH_DELAY, PH_WAIT, PH_RETRY_RUN, PH_LATCHED, PH_HOLD
  } phase_type;

  typedef struct packed {
    phase_type      phase;
    logic [CNT_W+2:0] timer;
    logic [2:0]     tries;
    logic           allow;
  } state_type;

  state_type s_q, s_d;
  vin_supervisor_pkg::resp_type resp;
  logic [2:0]       retry;
  logic [CNT_W+2:0] span;

  assign resp  = vin_supervisor_pkg::resp_type'(action[7:6]);
  assign retry = action[5:3];
  // Same three-bit count serves as delay and retry spacing
  assign span  = (CNT_W+3)'(action[2:0]) * unit_cycles;

  always_comb begin
    s_d = s_q;
    unique case (s_q.phase)
      PH_IDLE: begin
        s_d.allow = 1'b1;
        if (fault && run_req) begin
          unique case (resp)
            vin_supervisor_pkg::RESP_IGNORE: ;
            vin_supervisor_pkg::RESP_DELAY_OFF: begin
              s_d.timer = span;
              s_d.phase = PH_DELAY;
            end
            vin_supervisor_pkg::RESP_OFF_NOW: begin
              s_d.allow = 1'b0;
              s_d.timer = span;
              s_d.tries = retry;
              s_d.phase = (retry == vin_supervisor_pkg::RETRY_NONE)
                          ? PH_LATCHED : PH_WAIT;
            end
            vin_supervisor_pkg::RESP_OFF_WHILE: begin
              s_d.allow = 1'b0;
              s_d.phase = PH_HOLD;
            end
          endcase
        end
      end
      PH_DELAY: begin
        if (!run_req || !fault) begin
          s_d.phase = PH_IDLE;
        end else if (s_q.timer == '0) begin
          s_d.allow = 1'b0;
          s_d.timer = span;
          s_d.tries = retry;
          s_d.phase = (retry == vin_supervisor_pkg::RETRY_NONE)
                      ? PH_LATCHED : PH_WAIT;
        end else begin
          s_d.timer = s_q.timer - 1'b1;
        end
      end
      PH_WAIT: begin
        s_d.allow = 1'b0;
        if (!run_req) begin
          s_d.phase = PH_IDLE;
        end else if (halt) begin
          s_d.phase = PH_LATCHED;
        end else if (s_q.timer == '0) begin
          s_d.allow = 1'b1;
          s_d.timer = span;
          if (retry != vin_supervisor_pkg::RETRY_CONTINUOUS) begin
            s_d.tries = s_q.tries - 1'b1;
          end
          s_d.phase = PH_RETRY_RUN;
        end else begin
          s_d.timer = s_q.timer - 1'b1;
        end
      end
      PH_RETRY_RUN: begin
        s_d.allow = 1'b1;
        if (!run_req) begin
          s_d.phase = PH_IDLE;
        end else if (halt) begin
          s_d.allow = 1'b0;
          s_d.phase = PH_LATCHED;
        end else if (fault) begin
          s_d.allow = 1'b0;
          s_d.timer = span;
          // Continuous mode retries again regardless of the remaining tries
          if (retry == vin_supervisor_pkg::RETRY_CONTINUOUS ||
              s_q.tries != 3'h0) begin
            s_d.phase = PH_WAIT;
          end else begin
            s_d.phase = PH_LATCHED;
          end
        end else if (s_q.timer == '0) begin
          s_d.phase = PH_IDLE;
        end else begin
          s_d.timer = s_q.timer - 1'b1;
        end
      end
      PH_LATCHED: begin
        // Only dropping run_req clears the shutdown
        s_d.allow = 1'b0;
        if (!run_req) begin
          s_d.phase = PH_IDLE;
        end
      end
      PH_HOLD: begin
        s_d.allow = !(fault && run_req) ? 1'b1 : 1'b0;
        if (!(fault && run_req)) begin
          s_d.phase = PH_IDLE;
        end
      end
      default: begin
        s_d.phase = PH_LATCHED;
        s_d.allow = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '{phase: PH_IDLE, timer: '0, tries: 3'h0, allow: 1'b1};
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign allow_q   = s_q.allow;
  assign latched_q = (s_q.phase == PH_LATCHED);

endmodule // fault_action_engine

//--- design/input_voltage_fault_supervisor.sv
// Input-voltage supervisor: thresholds, fault actions, input status.
// Assumes a command decoder and a voltage measurement on clk, and a
// pin strap that is static while the part runs.

// Behaviour
// - An input overvoltage fault is declared while the input exceeds the overvoltage fault limit, which resets to d3a0h and spans 0 V to 16 V.
// - Above the overvoltage warning limit (reset d360h) the catch-all and input summary bits, the overvoltage warning bit and the alert are set.
// - Below the undervoltage warning limit (reset 4.5 V, up to 12 V) the catch-all and input summary bits, the undervoltage warning bit and the alert are set.
// - An input undervoltage fault is declared below the undervoltage fault limit, whose reset value comes from the pin strap.
// - A declared undervoltage fault stays active until the input rises above the undervoltage warning limit.
// - Response 00 ignores the fault; response 01 waits the delay of bits 2:0, then disables and retries per bits 5:3.
// - Response 10 disables at once and then retries per bits 5:3.
// - Response 11 keeps the output off while the fault lasts and lets it run again once it is gone.
// - Every fault sets its status bit whatever the response, and only the clear-faults command clears it.
// - Retry count 000 makes no restart and keeps the output off until the device is restarted.
// - Retry count 001 to 110 restarts exactly that many times, spaced by the time of bits 2:0.
// - Retry count 111 restarts endlessly until disabled or another fault latches the output off.
// - The count in bits 2:0 sets both the delay before acting and the spacing between restarts.
// - Both fault-response bytes reset to 80h, immediate disable with no restart.
// - Input faults and warnings show in status word bit 13, and bit 0 flags those not covered by bits 7:1.
module input_voltage_fault_supervisor #(
  parameter int UNIT_CYCLES = vin_supervisor_pkg::TIME_UNIT_CYC,
  parameter int CNT_W       = 16
) (
  input  wire logic                             clk,
  input  wire logic                             arst_n,
  input  wire logic                             ce,
  input  wire logic                             cmd_valid,
  input  wire vin_supervisor_pkg::cmd_type      cmd,
  input  wire logic [vin_supervisor_pkg::FIX_W-1:0] vin_meas,
  input  wire logic [15:0]                      uv_strap,
  input  wire logic                             run_req,
  output logic                                  rsp_valid_q,
  output vin_supervisor_pkg::rsp_type           rsp_q,
  output logic                                  alert_n_q,
  output logic                                  output_on_q,
  output logic [15:0]                           status_word_q
);

  initial begin
    if (UNIT_CYCLES < 1 || UNIT_CYCLES >= (1 << CNT_W)) begin
      $error("input_voltage_fault_supervisor: unit does not fit counter");
    end
  end

  localparam int FW = vin_supervisor_pkg::FIX_W;
  localparam int NLIM = 4;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] ov_fault_limit;
    logic [7:0]  ov_fault_action;
    logic [15:0] ov_warn_limit;
    logic [15:0] uv_warn_limit;
    logic [15:0] uv_fault_limit;
    logic [7:0]  uv_fault_action;
    logic [15:0] strap_meta;
    logic [15:0] strap_sync;
    logic [1:0]  strap_age;
    logic        uv_fault_active;
    logic [7:0]  status_input;
    logic        rsp_valid;
    vin_supervisor_pkg::rsp_type rsp;
    logic        alert_n;
    logic        output_on;
    logic [15:0] status_word;
  } state_type;

  state_type s_q, s_d;

  // ----------------------------------------------------------------
  // Threshold decoders
  // ----------------------------------------------------------------
  logic [15:0]   lim_raw [NLIM];
  logic [FW-1:0] lim_fix [NLIM];

  assign lim_raw[0] = s_q.ov_fault_limit;
  assign lim_raw[1] = s_q.ov_warn_limit;
  assign lim_raw[2] = s_q.uv_warn_limit;
  assign lim_raw[3] = s_q.uv_fault_limit;

  for (genvar i = 0; i < NLIM; i++) begin : g_dec
    l11_to_fixed #(
      .FIX_W (FW),
      .FRAC  (vin_supervisor_pkg::FIX_FRAC)
    ) u_dec (
      .clk     (clk),
      .arst_n  (arst_n),
      .ce      (ce),
      .l11     (lim_raw[i]),
      .value_q (lim_fix[i])
    );
  end

  // Limits are trusted once the strap has loaded, one cycle before it is decoded
  logic limits_ready;
  assign limits_ready = (s_q.strap_age == 2'h3);

  logic ov_fault_cond;
  logic ov_warn_cond;
  logic uv_warn_cond;
  logic uv_fault_cond;

  assign ov_fault_cond = limits_ready && (vin_meas > lim_fix[0]);
  assign ov_warn_cond  = limits_ready && (vin_meas > lim_fix[1]);
  assign uv_warn_cond  = limits_ready && (vin_meas < lim_fix[2]);
  assign uv_fault_cond = limits_ready && (vin_meas < lim_fix[3]);

  // ----------------------------------------------------------------
  // Fault action engines
  // ----------------------------------------------------------------
  logic ov_allow;
  logic uv_allow;
  logic ov_latched;
  logic uv_latched;

  // Each engine treats a latched shutdown by the other one as a halt
  fault_action_engine #(
    .CNT_W (CNT_W)
  ) u_ov_action (
    .clk         (clk),
    .arst_n      (arst_n),
    .ce          (ce),
    .fault       (ov_fault_cond),
    .run_req     (run_req),
    .halt        (uv_latched),
    .action      (s_q.ov_fault_action),
    .unit_cycles (CNT_W'(UNIT_CYCLES)),
    .allow_q     (ov_allow),
    .latched_q   (ov_latched)
  );

  fault_action_engine #(
    .CNT_W (CNT_W)
  ) u_uv_action (
    .clk         (clk),
    .arst_n      (arst_n),
    .ce          (ce),
    .fault       (s_q.uv_fault_active),
    .run_req     (run_req),
    .halt        (ov_latched),
    .action      (s_q.uv_fault_action),
    .unit_cycles (CNT_W'(UNIT_CYCLES)),
    .allow_q     (uv_allow),
    .latched_q   (uv_latched)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic [7:0] set_input;
  logic       clear_req;

  always_comb begin
    s_d = s_q;
    set_input = 8'h0;
    clear_req = 1'b0;

    // Strap: two flops, then loaded once after reset release
    s_d.strap_meta = uv_strap;
    s_d.strap_sync = s_q.strap_meta;
    if (s_q.strap_age != 2'h3) begin
      s_d.strap_age = s_q.strap_age + 2'h1;
    end
    if (s_q.strap_age == 2'h2) begin
      s_d.uv_fault_limit = s_q.strap_sync;
    end

    // Undervoltage fault with hysteresis to the warning limit
    if (uv_fault_cond) begin
      s_d.uv_fault_active = 1'b1;
    end else if (limits_ready && vin_meas > lim_fix[2]) begin
      s_d.uv_fault_active = 1'b0;
    end

    set_input[vin_supervisor_pkg::SI_OV_FAULT_BIT] = ov_fault_cond;
    set_input[vin_supervisor_pkg::SI_OV_WARN_BIT]  = ov_warn_cond;
    set_input[vin_supervisor_pkg::SI_UV_WARN_BIT]  = uv_warn_cond;
    set_input[vin_supervisor_pkg::SI_UV_FAULT_BIT] =
      s_q.uv_fault_active;

    // Commands
    s_d.rsp_valid = 1'b0;
    if (cmd_valid) begin
      s_d.rsp_valid  = 1'b1;
      s_d.rsp.error  = 1'b0;
      s_d.rsp.data   = 16'h0;
      unique case (cmd.code)
        vin_supervisor_pkg::CMD_CLEAR_FAULTS: begin
          clear_req = cmd.write;
          s_d.rsp.error = !cmd.write;
        end
        vin_supervisor_pkg::CMD_OV_FAULT_LIMIT: begin
          if (cmd.write) s_d.ov_fault_limit = cmd.data;
          s_d.rsp.data = s_q.ov_fault_limit;
        end
        vin_supervisor_pkg::CMD_OV_FAULT_ACTION: begin
          if (cmd.write) s_d.ov_fault_action = cmd.data[7:0];
          s_d.rsp.data = {8'h0, s_q.ov_fault_action};
        end
        vin_supervisor_pkg::CMD_OV_WARN_LIMIT: begin
          if (cmd.write) s_d.ov_warn_limit = cmd.data;
          s_d.rsp.data = s_q.ov_warn_limit;
        end
        vin_supervisor_pkg::CMD_UV_WARN_LIMIT: begin
          if (cmd.write) s_d.uv_warn_limit = cmd.data;
          s_d.rsp.data = s_q.uv_warn_limit;
        end
        vin_supervisor_pkg::CMD_UV_FAULT_LIMIT: begin
          if (cmd.write) s_d.uv_fault_limit = cmd.data;
          s_d.rsp.data = s_q.uv_fault_limit;
        end
        vin_supervisor_pkg::CMD_UV_FAULT_ACTION: begin
          if (cmd.write) s_d.uv_fault_action = cmd.data[7:0];
          s_d.rsp.data = {8'h0, s_q.uv_fault_action};
        end
        vin_supervisor_pkg::CMD_STATUS_BYTE: begin
          s_d.rsp.error = cmd.write;
          s_d.rsp.data  = {8'h0, s_q.status_word[7:0]};
        end
        vin_supervisor_pkg::CMD_STATUS_WORD: begin
          s_d.rsp.error = cmd.write;
          s_d.rsp.data  = s_q.status_word;
        end
        vin_supervisor_pkg::CMD_STATUS_INPUT: begin
          s_d.rsp.error = cmd.write;
          s_d.rsp.data  = {8'h0, s_q.status_input};
        end
        default: begin
          s_d.rsp.error = 1'b1;
        end
      endcase
    end

    // Sticky bits: a new event outranks a clear in the same cycle
    if (clear_req) begin
      s_d.status_input = set_input;
    end else begin
      s_d.status_input = s_q.status_input | set_input;
    end

    s_d.status_word = 16'h0;
    s_d.status_word[vin_supervisor_pkg::SW_INPUT_BIT] =
      |s_d.status_input;
    s_d.status_word[vin_supervisor_pkg::SW_UV_FAULT_BIT] =
      s_d.status_input[vin_supervisor_pkg::SI_UV_FAULT_BIT];
    s_d.status_word[vin_supervisor_pkg::SW_OTHER_BIT] =
      s_d.status_input[vin_supervisor_pkg::SI_OV_FAULT_BIT] |
      s_d.status_input[vin_supervisor_pkg::SI_OV_WARN_BIT] |
      s_d.status_input[vin_supervisor_pkg::SI_UV_WARN_BIT];
    s_d.alert_n   = !(|s_d.status_input);
    s_d.output_on = run_req && ov_allow && uv_allow && limits_ready;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '{
        ov_fault_limit:  vin_supervisor_pkg::OV_FAULT_LIMIT_RST,
        ov_fault_action: vin_supervisor_pkg::FAULT_ACTION_RST,
        ov_warn_limit:   vin_supervisor_pkg::OV_WARN_LIMIT_RST,
        uv_warn_limit:   vin_supervisor_pkg::UV_WARN_LIMIT_RST,
        uv_fault_limit:  16'h0,
        uv_fault_action: vin_supervisor_pkg::FAULT_ACTION_RST,
        strap_meta:      16'h0,
        strap_sync:      16'h0,
        strap_age:       2'h0,
        uv_fault_active: 1'b0,
        status_input:    8'h0,
        rsp_valid:       1'b0,
        rsp:             '0,
        alert_n:         1'b1,
        output_on:       1'b0,
        status_word:     16'h0
      };
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign rsp_valid_q   = s_q.rsp_valid;
  assign rsp_q         = s_q.rsp;
  assign alert_n_q     = s_q.alert_n;
  assign output_on_q   = s_q.output_on;
  assign status_word_q = s_q.status_word;

endmodule // input_voltage_fault_supervisor

//--- design/l11_to_fixed.sv
// Linear-11 threshold to unsigned fixed point, one cycle of latency.
// Assumes the caller compares against a measurement in the same format.
module l11_to_fixed #(
  parameter int FIX_W = vin_supervisor_pkg::FIX_W,
  parameter int FRAC  = vin_supervisor_pkg::FIX_FRAC
) (
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic             ce,
  input  wire logic [15:0]      l11,
  output logic      [FIX_W-1:0] value_q
);

  initial begin
    if (FIX_W < 12 || FIX_W > 40 || FRAC > 16) begin
      $error("l11_to_fixed: unsupported width");
    end
  end

  logic signed [6:0] shift;
  logic [63:0]       wide;
  logic [FIX_W-1:0]  value_d;

  // Negative values clamp to zero; too-large values saturate
  always_comb begin
    shift = 7'(signed'(l11[15:vin_supervisor_pkg::L11_EXP_LSB]))
            + 7'(FRAC);
    wide  = 64'h0;
    if (!l11[10]) begin
      if (shift < 0) begin
        wide = {53'h0, l11[10:0]} >> (-shift);
      end else begin
        wide = {53'h0, l11[10:0]} << shift;
      end
    end
    if (|wide[63:FIX_W]) begin
      value_d = '1;
    end else begin
      value_d = wide[FIX_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      value_q <= '0;
    end else if (ce) begin
      value_q <= value_d;
    end
  end

endmodule // l11_to_fixed

//--- design/vin_supervisor_pkg.sv
// Shared constants and carriers of the input-voltage fault supervisor.
// Assumes a command decoder on the same clock that hands over whole
// management-bus commands, one per valid cycle.
package vin_supervisor_pkg;

  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_CLEAR_FAULTS    = 8'h03;
  localparam logic [7:0] CMD_OV_FAULT_LIMIT  = 8'h55;
  localparam logic [7:0] CMD_OV_FAULT_ACTION = 8'h56;
  localparam logic [7:0] CMD_OV_WARN_LIMIT   = 8'h57;
  localparam logic [7:0] CMD_UV_WARN_LIMIT   = 8'h58;
  localparam logic [7:0] CMD_UV_FAULT_LIMIT  = 8'h59;
  localparam logic [7:0] CMD_UV_FAULT_ACTION = 8'h5a;
  localparam logic [7:0] CMD_STATUS_BYTE     = 8'h78;
  localparam logic [7:0] CMD_STATUS_WORD     = 8'h79;
  localparam logic [7:0] CMD_STATUS_INPUT    = 8'h7c;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] OV_FAULT_LIMIT_RST = 16'hd3a0;
  localparam logic [15:0] OV_WARN_LIMIT_RST  = 16'hd360;
  // 4.5 V as linear-11: mantissa 9, exponent -1
  localparam logic [15:0] UV_WARN_LIMIT_RST  = 16'hf809;
  localparam logic [7:0]  FAULT_ACTION_RST   = 8'h80;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int L11_EXP_LSB    = 11;
  localparam int ACT_RESP_LSB   = 6;
  localparam int ACT_RETRY_LSB  = 3;
  localparam int ACT_TIME_LSB   = 0;
  localparam int SW_INPUT_BIT   = 13;
  localparam int SW_UV_FAULT_BIT = 3;
  localparam int SW_OTHER_BIT   = 0;
  localparam int SI_OV_FAULT_BIT = 7;
  localparam int SI_OV_WARN_BIT = 6;
  localparam int SI_UV_WARN_BIT = 5;
  localparam int SI_UV_FAULT_BIT = 4;
  localparam logic [2:0] RETRY_NONE       = 3'h0;
  localparam logic [2:0] RETRY_CONTINUOUS = 3'h7;

  // ----------------------------------------------------------------
  // Fixed point and timing
  // ----------------------------------------------------------------
  localparam int FIX_W    = 24;
  localparam int FIX_FRAC = 8;
  localparam int CLK_PERIOD_NS  = 4;
  localparam int TIME_UNIT_NS   = 10000;
  localparam int TIME_UNIT_CYC  =
    (TIME_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    RESP_IGNORE, RESP_DELAY_OFF, RESP_OFF_NOW, RESP_OFF_WHILE
  } resp_type;

  typedef struct packed {
    logic        write;
    logic [7:0]  code;
    logic [15:0] data;
  } cmd_type;

  typedef struct packed {
    logic        error;
    logic [15:0] data;
  } rsp_type;

endpackage

//--- dv/input_voltage_fault_supervisor_properties.sv
// Checker of command answers, status summary and output enable.
// Assumes it is bound into the supervisor and sees its ports only.
module input_voltage_fault_supervisor_properties #(
  parameter int UNIT_CYCLES = vin_supervisor_pkg::TIME_UNIT_CYC,
  parameter int CNT_W       = 16
) (
  input wire logic                        clk,
  input wire logic                        arst_n,
  input wire logic                        ce,
  input wire logic                        cmd_valid,
  input wire vin_supervisor_pkg::cmd_type cmd,
  input wire logic                        run_req,
  input wire logic                        rsp_valid_q,
  input wire vin_supervisor_pkg::rsp_type rsp_q,
  input wire logic                        alert_n_q,
  input wire logic                        output_on_q,
  input wire logic [15:0]                 status_word_q
);
  timeunit 1ns;
  timeprecision 100ps;
  logic clr;
  assign clr = cmd_valid & ce & cmd.write
             & (cmd.code == vin_supervisor_pkg::CMD_CLEAR_FAULTS);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  rsp_one_cycle_a:
    assert property (rsp_valid_q == $past(cmd_valid & ce))
    else $error("answer pulse out of place");
  bad_code_a:
    assert property (cmd_valid && ce && cmd.code == 8'h00 |=> rsp_q.error)
    else $error("unknown code not refused");
  status_write_a:
    assert property (cmd_valid && ce && cmd.write
      && cmd.code == vin_supervisor_pkg::CMD_STATUS_WORD
      |=> rsp_valid_q && rsp_q.error)
    else $error("status write not refused");
  sw_summary_a:
    assert property (status_word_q[3] || status_word_q[0]
      |-> status_word_q[13])
    else $error("input summary bit missing");
  sw_unused_a:
    assert property ((status_word_q & 16'hdff6) == 16'h0000)
    else $error("foreign status bit set");
  alert_tie_a:
    assert property (alert_n_q == !status_word_q[13])
    else $error("alert disagrees with status");
  // Latched bits may only drop shortly after a clear command
  fault_sticky_a:
    assert property ($fell(status_word_q[13]) |-> $past(clr)
      || $past(clr, 2))
    else $error("status dropped without clear");
  run_off_a:
    assert property (!run_req |=> !output_on_q)
    else $error("output on while not wanted");
  cover property ($fell(output_on_q));
  cover property ($rose(status_word_q[13]));
  cover property (clr);
endmodule // input_voltage_fault_supervisor_properties

bind input_voltage_fault_supervisor
  input_voltage_fault_supervisor_properties #(
    .UNIT_CYCLES(UNIT_CYCLES), .CNT_W(CNT_W)) i_props (
    .clk(clk), .arst_n(arst_n), .ce(ce), .cmd_valid(cmd_valid),
    .cmd(cmd), .run_req(run_req), .rsp_valid_q(rsp_valid_q),
    .rsp_q(rsp_q), .alert_n_q(alert_n_q), .output_on_q(output_on_q),
    .status_word_q(status_word_q));

//--- dv/pmbus_host_model.sv
// Host model: issues one command and collects its answer.
// Assumes the answer is there half a cycle after the taking edge.
module pmbus_host_model (
  input  wire logic                        clk,
  output vin_supervisor_pkg::cmd_type      cmd,
  output logic                             cmd_valid,
  input  wire logic                        rsp_valid_q,
  input  wire vin_supervisor_pkg::rsp_type rsp_q
);
  timeunit 1ns;
  timeprecision 100ps;
  initial cmd_valid = 1'b0;
  initial cmd = '0;
  // One transfer: command held for one cycle, answer sampled at the next negedge
  task automatic xfer(input logic w, input logic [7:0] c,
    input logic [15:0] d, output vin_supervisor_pkg::rsp_type r);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd <= {w, c, d};
    @(posedge clk);
    cmd_valid <= 1'b0;
    // Released word flips so a stale value never reads as valid
    cmd <= {1'b0, 8'hff, ~d};
    @(negedge clk);
    r = rsp_valid_q ? rsp_q : 'x;
  endtask
endmodule // pmbus_host_model

//--- dv/test_input_voltage_fault_supervisor.sv
// Bench: limits, status, fault actions of the input supervisor.
// Assumes a 250 MHz clock; unit shortened to 4 cycles.
module test_input_voltage_fault_supervisor;
  timeunit 1ns;
  timeprecision 100ps;
  logic                        clk = 1'b0;
  logic                        arst_n = 1'b0;
  logic                        run_req = 1'b1;
  logic                        cmd_valid, rsp_valid_q, alert_n_q, on_q;
  logic [23:0]                 vin = 24'h000c00;
  logic [15:0]                 sw, lfsr = 16'h0062;
  vin_supervisor_pkg::cmd_type cmd;
  vin_supervisor_pkg::rsp_type rsp_q, r;
  int                          err_count = 0, num_checks = 0, n;
  logic [15:0] rst_v [6] = '{16'hd3a0, 16'h0080, 16'hd360, 16'hf809,
                             16'hf808, 16'h0080};
  logic [7:0]  act [5] = '{8'h00, 8'h80, 8'h91, 8'h51, 8'hc0};
  logic [15:0] exp_w [5] = '{16'h0001, 16'h0, 16'h0200, 16'h0200, 16'h0};
  always #2 clk = ~clk;
  input_voltage_fault_supervisor #(.UNIT_CYCLES(4)) i_dut (
    .clk(clk), .arst_n(arst_n), .ce(1'b1), .cmd_valid(cmd_valid),
    .cmd(cmd), .vin_meas(vin), .uv_strap(16'hf808), .run_req(run_req),
    .rsp_valid_q(rsp_valid_q), .rsp_q(rsp_q), .alert_n_q(alert_n_q),
    .output_on_q(on_q), .status_word_q(sw));
  pmbus_host_model i_host (.clk(clk), .cmd(cmd), .cmd_valid(cmd_valid),
    .rsp_valid_q(rsp_valid_q), .rsp_q(rsp_q));
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [15:0] nxt(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    i_host.xfer(1'b1, c, d, r);
  endtask
  task automatic rd(input logic [7:0] c, input logic [15:0] e);
    i_host.xfer(1'b0, c, 16'h0000, r);
    chk(r.data, e);
  endtask
  task automatic setv(input logic [23:0] v);
    @(posedge clk);
    vin <= v;
  endtask
  // Counts output restarts; fixed window, never open-ended
  task automatic ups(input int cyc);
    logic p;
    n = 0;
    p = on_q;
    repeat (cyc) begin
      @(negedge clk);
      n += int'(on_q & ~p);
      p = on_q;
    end
  endtask
  task automatic recover();
    wr(8'h03, 16'h0000);
    @(posedge clk);
    run_req <= 1'b0;
    repeat (2) @(posedge clk);
    run_req <= 1'b1;
    ups(5);
    chk(16'(on_q), 16'h0001);
  endtask
  task automatic give_verdict();
    if (err_count == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge clk);
    err_count++;
    give_verdict();
  end
  initial begin
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    repeat (6) @(posedge clk);
    foreach (rst_v[i]) rd(8'(8'h55 + i), rst_v[i]);
    foreach (rst_v[i]) begin
      lfsr = nxt(lfsr);
      wr(8'(8'h55 + i), lfsr);
      rd(8'(8'h55 + i), (i % 4 == 1) ? {8'h00, lfsr[7:0]} : lfsr);
      wr(8'(8'h55 + i), rst_v[i]);
    end
    for (int c = 0; c < 2; c++) begin
      wr(c ? 8'h79 : 8'h00, 16'hffff);
      chk(16'(r.error), 16'h0001);
    end
    recover();
    setv(24'h000e00);
    rd(8'h79, 16'h2001);
    chk(16'(alert_n_q), 16'h0000);
    rd(8'h7c, 16'h0040);
    setv(24'h000c00);
    rd(8'h79, 16'h2001);
    wr(8'h03, 16'h0000);
    rd(8'h79, 16'h0000);
    foreach (act[i]) begin
      wr(8'h56, {8'h00, act[i]});
      setv(24'h000f00);
      ups(200);
      chk({8'(n), 7'h0, on_q}, exp_w[i]);
      setv(24'h000c00);
      ups(6);
      if (act[i] == 8'hc0) chk(16'(on_q), 16'h0001);
      recover();
    end
    wr(8'h56, 16'h00b9);
    setv(24'h000f00);
    ups(200);
    chk(16'(n > 4), 16'h0001);
    setv(24'h000c00);
    recover();
    // Long delay: a short glitch must not shut the output
    wr(8'h56, 16'h0043);
    setv(24'h000f00);
    repeat (6) @(posedge clk);
    vin <= 24'h000c00;
    ups(20);
    chk(16'(on_q), 16'h0001);
    setv(24'h000f00);
    ups(8);
    chk(16'(on_q), 16'h0001);
    ups(12);
    chk(16'(on_q), 16'h0000);
    setv(24'h000c00);
    recover();
    wr(8'h5a, 16'h00c0);
    setv(24'h000380);
    ups(6);
    chk(16'(on_q), 16'h0000);
    rd(8'h79, 16'h2009);
    setv(24'h000440);
    ups(10);
    chk(16'(on_q), 16'h0000);
    setv(24'h000500);
    ups(6);
    chk(16'(on_q), 16'h0001);
    rd(8'h7c, 16'h0030);
    rd(8'h78, 16'h0009);
    give_verdict();
  end
endmodule // test_input_voltage_fault_supervisor
